// [common/hbp_pkg.sv]
package hbp_pkg;
  localparam int CNT_W  = 16;
  localparam int NCH    = 3;
  // apb register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TOP    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CMP0   = 8'h10;
  localparam logic [7:0] ADDR_CH0    = 8'h20;
  localparam logic [7:0] CH_STRIDE   = 8'h04;
  // channel control fields
  localparam int CH_ENA_BIT = 0;
  localparam int CH_TRI_BIT = 1;
  // ctrl fields
  localparam int CTRL_RUN_BIT = 0;
  // reset values
  localparam logic [15:0] TOP_RST = 16'h03e8;
  localparam logic [15:0] CMP_RST = 16'h01f4;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } hbp_dir_type;
endpackage

// [src/hbp_shadow_mem.sv]
// small staging memory for compare words, registered read port
module hbp_shadow_mem
  import hbp_pkg::*;
#(
  parameter int DW = 32,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input  wire logic          REF_CLK,
  input  wire logic          ARST_N,
  input  wire logic          WE,
  input  wire logic [AW-1:0] WADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic [AW-1:0] RADDR,
  output logic      [DW-1:0] RDATA
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= DW'({CMP_RST, CMP_RST});
      end
      RDATA <= '0;
    end else begin
      if (WE) begin
        mem[WADDR] <= WDATA;
      end
      RDATA <= mem[RADDR];
    end
  end
endmodule // hbp_shadow_mem

// [src/hbp_two_phase_pwm_unit.sv]
// The register offsets and the APB register port were left to the implementer.
module hbp_two_phase_pwm_unit
  import hbp_pkg::*;
#(
  parameter int NUM_CH = NCH
) (
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic      [NUM_CH-1:0] LEG_A_HIGH_SWITCH,
  output logic      [NUM_CH-1:0] LEG_A_LOW_SWITCH,
  output logic      [NUM_CH-1:0] LEG_B_HIGH_SWITCH,
  output logic      [NUM_CH-1:0] LEG_B_LOW_SWITCH,
  output logic                   ADC_READ_OK
);
  localparam int AW = 2;

  function automatic logic is_ch_addr(input logic [7:0] a, input logic [7:0] base);
    is_ch_addr = (a >= base) && (a < base + 8'(NUM_CH) * CH_STRIDE) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [AW-1:0] ch_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    ch_idx = d[AW+1:2];
  endfunction

  // apb decode
  wire        setup_ph  = PSEL && !PENABLE;
  wire        access_ph = PSEL && PENABLE;
  wire        hit_ctrl  = (PADDR == ADDR_CTRL);
  wire        hit_top   = (PADDR == ADDR_TOP);
  wire        hit_stat  = (PADDR == ADDR_STATUS);
  wire        hit_cmp   = is_ch_addr(PADDR, ADDR_CMP0);
  wire        hit_ch    = is_ch_addr(PADDR, ADDR_CH0);
  wire        hit_any   = hit_ctrl | hit_top | hit_stat | hit_cmp | hit_ch;
  wire        wr_en     = access_ph && PWRITE && PREADY && hit_any;

  logic              run;
  logic [15:0]       top_shadow;
  logic [15:0]       top_act;
  logic [15:0]       cnt;
  hbp_dir_type       dir;
  logic [NUM_CH-1:0] ena_shadow;
  logic [NUM_CH-1:0] tri_shadow;
  logic [NUM_CH-1:0] ena_act;
  logic [NUM_CH-1:0] tri_act;
  logic [15:0]       cmpa_act [NUM_CH];
  logic [15:0]       cmpb_act [NUM_CH];
  logic [15:0]       cmpa_stage [NUM_CH];
  logic [15:0]       cmpb_stage [NUM_CH];
  logic [AW-1:0]     scan_idx;
  logic [AW-1:0]     prev_idx;
  logic              scan_valid;
  logic              rd_wait;
  logic [31:0]       mem_rdata;
  logic [31:0]       next_prdata;

  // a compare read takes the memory port from the scan for setup and both access cycles
  wire          bus_cmp_rd  = PSEL && !PWRITE && hit_cmp;
  wire          cmp_rd_take = access_ph && !PWRITE && hit_cmp && !rd_wait;
  wire          rd_capture  = (setup_ph && !PWRITE && !hit_cmp) || cmp_rd_take;
  wire [AW-1:0] next_scan   = (scan_idx == AW'(NUM_CH - 1)) ? '0 : scan_idx + 1'b1;

  // compare reads come through the registered memory port: one wait state
  hbp_shadow_mem #(.DW(32), .DEPTH(1 << AW), .AW(AW)) u_mem (
    .REF_CLK (REF_CLK),
    .ARST_N  (ARST_N),
    .WE      (wr_en && hit_cmp),
    .WADDR   (ch_idx(PADDR, ADDR_CMP0)),
    .WDATA   (PWDATA),
    .RADDR   (bus_cmp_rd ? ch_idx(PADDR, ADDR_CMP0) : scan_idx),
    .RDATA   (mem_rdata)
  );

  assign PREADY  = !cmp_rd_take;
  assign PSLVERR = access_ph && PREADY && !hit_any;

  // triangle counter
  wire at_bottom = (cnt == CNT_ZERO) && (dir == DIR_UP);
  wire at_peak   = (cnt >= top_act) && (dir == DIR_UP);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt <= CNT_ZERO;
      dir <= DIR_UP;
    end else if (!run) begin
      cnt <= CNT_ZERO;
      dir <= DIR_UP;
    end else begin
      case (dir)
        DIR_UP: begin
          if (cnt >= top_act) begin
            dir <= DIR_DOWN;
            cnt <= (cnt > CNT_ZERO) ? cnt - CNT_ONE : CNT_ZERO;
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        DIR_DOWN: begin
          // stops at zero so a tiny peak can never wrap the counter
          if (cnt <= CNT_ONE) begin
            dir <= DIR_UP;
            cnt <= CNT_ZERO;
          end else begin
            cnt <= cnt - CNT_ONE;
          end
        end
        default: dir <= DIR_UP;
      endcase
    end
  end

  // the scan keeps a staged copy of every compare word so that all channels
  // move in one edge at bottom; a word written late in a period waits a period
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scan_idx   <= '0;
      prev_idx   <= '0;
      scan_valid <= 1'b0;
    end else begin
      scan_valid <= !bus_cmp_rd;
      prev_idx   <= scan_idx;
      if (!bus_cmp_rd) begin
        scan_idx <= next_scan;
      end
    end
  end

  // memory data lags its address by one cycle
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cmpa_stage[i] <= CMP_RST;
        cmpb_stage[i] <= CMP_RST;
      end
    end else if (scan_valid) begin
      cmpa_stage[prev_idx] <= mem_rdata[15:0];
      cmpb_stage[prev_idx] <= mem_rdata[31:16];
    end
  end

  // bottom transfer, or straight through while stopped
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      top_act <= TOP_RST;
      ena_act <= '0;
      tri_act <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        cmpa_act[i] <= CMP_RST;
        cmpb_act[i] <= CMP_RST;
      end
    end else if (at_bottom || !run) begin
      top_act <= top_shadow;
      ena_act <= ena_shadow;
      tri_act <= tri_shadow;
      for (int i = 0; i < NUM_CH; i++) begin
        cmpa_act[i] <= cmpa_stage[i];
        cmpb_act[i] <= cmpb_stage[i];
      end
    end
  end

  // registers written by software
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run        <= 1'b0;
      top_shadow <= TOP_RST;
      ena_shadow <= '0;
      tri_shadow <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        run <= PWDATA[CTRL_RUN_BIT];
      end
      if (hit_top) begin
        top_shadow <= PWDATA[15:0];
      end
      if (hit_ch) begin
        ena_shadow[ch_idx(PADDR, ADDR_CH0)] <= PWDATA[CH_ENA_BIT];
        tri_shadow[ch_idx(PADDR, ADDR_CH0)] <= PWDATA[CH_TRI_BIT];
      end
    end
  end

  // read path
  always_comb begin
    next_prdata = '0;
    if (hit_ctrl) next_prdata = {31'h0, run};
    else if (hit_top) next_prdata = {16'h0, top_shadow};
    else if (hit_stat) next_prdata = {dir == DIR_DOWN, 15'h0, cnt};
    else if (hit_ch) next_prdata = {30'h0, tri_shadow[ch_idx(PADDR, ADDR_CH0)],
                                    ena_shadow[ch_idx(PADDR, ADDR_CH0)]};
    else if (hit_cmp) next_prdata = mem_rdata;
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_wait <= 1'b0;
      PRDATA  <= '0;
    end else begin
      rd_wait <= cmp_rd_take;
      // data stands before pready so the master takes it at the handshake edge
      if (rd_capture) begin
        PRDATA <= next_prdata;
      end
    end
  end

  // phase compare and switch decode, registered
  logic [NUM_CH-1:0] ph_a;
  logic [NUM_CH-1:0] ph_b;
  logic [NUM_CH-1:0] drive;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ph_a[i]  = cnt < cmpa_act[i];
      ph_b[i]  = cnt < cmpb_act[i];
      drive[i] = run && ena_act[i] && !tri_act[i];
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LEG_A_HIGH_SWITCH <= '0;
      LEG_A_LOW_SWITCH  <= '0;
      LEG_B_HIGH_SWITCH <= '0;
      LEG_B_LOW_SWITCH  <= '0;
      ADC_READ_OK       <= 1'b0;
    end else begin
      LEG_A_HIGH_SWITCH <= drive & ph_a;
      LEG_A_LOW_SWITCH  <= drive & ~ph_a;
      LEG_B_HIGH_SWITCH <= drive & ph_b;
      LEG_B_LOW_SWITCH  <= drive & ~ph_b;
      ADC_READ_OK       <= run && at_peak;
    end
  end

  // a shoot-through would short the supply, so guard every leg
  property p_no_short;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ((LEG_A_HIGH_SWITCH & LEG_A_LOW_SWITCH) == '0) &&
      ((LEG_B_HIGH_SWITCH & LEG_B_LOW_SWITCH) == '0);
  endproperty
  a_no_short: assert property (p_no_short) else $error("leg short");

  property p_open_when_off;
    @(posedge REF_CLK) disable iff (!ARST_N)
      (drive == '0) |=> ((LEG_A_HIGH_SWITCH | LEG_A_LOW_SWITCH |
                          LEG_B_HIGH_SWITCH | LEG_B_LOW_SWITCH) == '0);
  endproperty
  a_open_when_off: assert property (p_open_when_off) else $error("switch closed off");

  property p_adc_at_peak;
    @(posedge REF_CLK) disable iff (!ARST_N)
      ADC_READ_OK |-> $past(cnt) >= $past(top_act) && $past(run);
  endproperty
  a_adc_at_peak: assert property (p_adc_at_peak) else $error("adc permit off peak");

  property p_top_hold;
    @(posedge REF_CLK) disable iff (!ARST_N)
      !$past(at_bottom) && $past(run) && run |-> $stable(top_act);
  endproperty
  a_top_hold: assert property (p_top_hold) else $error("top changed off bottom");

  property p_turn;
    @(posedge REF_CLK) disable iff (!ARST_N)
      run && dir == DIR_UP && cnt >= top_act ##1 run |-> dir == DIR_DOWN;
  endproperty
  a_turn: assert property (p_turn) else $error("no turn at top");

  property p_phase_a;
    @(posedge REF_CLK) disable iff (!ARST_N)
      drive[0] |=> LEG_A_HIGH_SWITCH[0] == ($past(cnt) < $past(cmpa_act[0]));
  endproperty
  a_phase_a: assert property (p_phase_a) else $error("phase a wrong");

  property p_phase_b;
    @(posedge REF_CLK) disable iff (!ARST_N)
      drive[0] |=> LEG_B_LOW_SWITCH[0] == ($past(cnt) >= $past(cmpb_act[0]));
  endproperty
  a_phase_b: assert property (p_phase_b) else $error("phase b wrong");

  property p_ena_load;
    @(posedge REF_CLK) disable iff (!ARST_N)
      at_bottom && run |=> ena_act == $past(ena_shadow);
  endproperty
  a_ena_load: assert property (p_ena_load) else $error("enable not loaded");
endmodule // hbp_two_phase_pwm_unit

// [testbench/hbp_bridge_model.sv]
// one h-bridge with a motor: counts shorts, decodes the switch pattern
module hbp_bridge_model
  import hbp_pkg::*;
(
  input  wire logic       REF_CLK,
  input  wire logic       A_HI,
  input  wire logic       A_LO,
  input  wire logic       B_HI,
  input  wire logic       B_LO,
  output logic      [1:0] RESULT,
  output int              SHORTS
);
  timeunit 1ns;
  timeprecision 1ps;
  logic short_now;
  // a closed pair in one leg shorts the supply; real silicon would burn, so we count
  assign short_now = (A_HI && A_LO) || (B_HI && B_LO);
  // 0 open, 1 positive, 2 negative, 3 brake
  assign RESULT = (A_HI && B_LO) ? 2'h1 : (A_LO && B_HI) ? 2'h2 :
                  ((A_HI && B_HI) || (A_LO && B_LO)) ? 2'h3 : 2'h0;
  always @(posedge REF_CLK) begin
    if (short_now === 1'b1) begin
      SHORTS <= SHORTS + 1;
    end
  end
endmodule // hbp_bridge_model

// [testbench/tb_hbp_two_phase_pwm_unit.sv]
module tb_hbp_two_phase_pwm_unit
  import hbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0;
  logic        arst_n  = 0;
  logic        psel    = 0;
  logic        penable = 0;
  logic        pwrite  = 0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ahs;
  logic [2:0]  als;
  logic [2:0]  bhs;
  logic [2:0]  bls;
  logic        adc_ok;
  logic [1:0]  res;
  int          shorts;
  int          fails   = 0;
  int          n_tests = 0;

  hbp_two_phase_pwm_unit hbp_two_phase_pwm_unit_inst (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LEG_A_HIGH_SWITCH(ahs),
    .LEG_A_LOW_SWITCH(als), .LEG_B_HIGH_SWITCH(bhs), .LEG_B_LOW_SWITCH(bls),
    .ADC_READ_OK(adc_ok));
  hbp_bridge_model hbp_bridge_model_inst (.REF_CLK(ref_clk), .A_HI(ahs[0]), .A_LO(als[0]),
    .B_HI(bhs[0]), .B_LO(bls[0]), .RESULT(res), .SHORTS(shorts));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait states depend on the register, so never assume a count
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one triangle period, measured between two adc permits
  task automatic period(output int len, output int ha, output int hb, output int pos,
                        output int neg);
    int k;
    k = 0;
    while (adc_ok !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    len = 0;
    ha  = 0;
    hb  = 0;
    pos = 0;
    neg = 0;
    do begin
      @(posedge ref_clk);
      len++;
      ha += int'(ahs[0]);
      hb += int'(bhs[0]);
      pos += int'(res == 2'h1);
      neg += int'(res == 2'h2);
      chk("leg_a_low", {31'h0, ~ahs[0]}, {31'h0, als[0]});
      chk("leg_b_low", {31'h0, ~bhs[0]}, {31'h0, bls[0]});
      chk("ch12_open", 32'h0, {28'h0, ahs[2:1] | als[2:1], bhs[2:1] | bls[2:1]});
    end while (adc_ok !== 1'b1 && len < 3000);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    int          top;
    int          ca;
    int          cb;
    int          len;
    int          ha;
    int          hb;
    int          pos;
    int          neg;
    void'($urandom(32'h6c72));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    apb(1'b0, ADDR_TOP, 32'h0, r, e);
    chk("top_reset", {16'h0, TOP_RST}, r);
    chk("top_err", 32'h0, {31'h0, e});
    apb(1'b0, ADDR_CMP0, 32'h0, r, e);
    chk("cmp_reset", {CMP_RST, CMP_RST}, r);
    apb(1'b0, 8'hfc, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b1, ADDR_CH0, 32'h1, r, e);
    apb(1'b1, ADDR_CH0 + 8'h08, 32'h3, r, e);
    for (int i = 0; i < 6; i++) begin
      top = 2 * (8 + int'($urandom % 16));
      ca  = (i == 0) ? top / 2 : (i == 1) ? 1 : 1 + int'($urandom % (top - 1));
      cb  = top - ca;
      apb(1'b1, ADDR_TOP, 32'(top), r, e);
      apb(1'b1, ADDR_CMP0, {16'(cb), 16'(ca)}, r, e);
      apb(1'b1, ADDR_CTRL, 32'h1, r, e);
      // first period may still run on old values; only loaded at bottom
      period(len, ha, hb, pos, neg);
      period(len, ha, hb, pos, neg);
      chk("period_len", 32'(2 * top), 32'(len));
      chk("phase_a_high", 32'(2 * ca - 1), 32'(ha));
      chk("phase_b_high", 32'(2 * cb - 1), 32'(hb));
      chk("motor_pos", 32'((ca > cb) ? 2 * (ca - cb) : 0), 32'(pos));
      chk("motor_neg", 32'((cb > ca) ? 2 * (cb - ca) : 0), 32'(neg));
    end
    chk("shorts", 32'h0, 32'(shorts));
    print_verdict();
  end
endmodule // tb_hbp_two_phase_pwm_unit
